// File: rtl/ifc_pkg.sv
// Operation
// - a request flag reads 1 while its request is pending, 0 otherwise.
// - acknowledging an interrupt clears that source's request flag.
// - mask flag 0 enables servicing, 1 disables it.
// - mask registers take bit, byte and group A word writes; reset to ffh.
// - in watchdog mode 1 the watchdog mask flag reads undefined.
// - port 0 output level changes set the matching external request flag.
// - priority registers select groups, take bit, byte and word writes; reset ffh.
// - rise and fall enable pair selects none, fall, rise or both edges.
// - edge enable registers hold bits 0 to 3, upper bits read 0, reset 00h.
// - port 4 config 000 is single-chip, 001 is falling edge detection.
// - port 4 config register takes bit and byte writes, resets to 00h.
// - status word holds global enable and service level; byte, bit, set, clear.
// - acknowledge or soft trap pushes status word and clears global enable.
// - maskable acknowledge copies the source priority flag into service level.
// - returns and pop restore the status word, push saves it; reset 02h.
// - global enable 1 permits maskable acknowledge, 0 blocks it.
// - service level 0 means high priority servicing in progress.
// - equal priority requests resolve by fixed default order, lowest index first.
package ifc_pkg;
   localparam int unsigned IFC_NSRC = 18;
   localparam logic [15:0] IFC_OFS_P4CFG = 16'hff47;
   localparam logic [15:0] IFC_OFS_RISE = 16'hff48;
   localparam logic [15:0] IFC_OFS_FALL = 16'hff49;
   localparam logic [15:0] IFC_OFS_REQ_AL = 16'hffe0;
   localparam logic [15:0] IFC_OFS_REQ_AH = 16'hffe1;
   localparam logic [15:0] IFC_OFS_REQ_B = 16'hffe2;
   localparam logic [15:0] IFC_OFS_MASK_AL = 16'hffe4;
   localparam logic [15:0] IFC_OFS_MASK_AH = 16'hffe5;
   localparam logic [15:0] IFC_OFS_MASK_B = 16'hffe6;
   localparam logic [15:0] IFC_OFS_PRIO_AL = 16'hffe8;
   localparam logic [15:0] IFC_OFS_PRIO_AH = 16'hffe9;
   localparam logic [15:0] IFC_OFS_PRIO_B = 16'hffea;
   localparam logic [15:0] IFC_OFS_PSW = 16'hfffe;
   localparam logic [15:0] IFC_OFS_BITOP = 16'hfff0;
   localparam logic [15:0] IFC_OFS_STATUS = 16'hfff4;
   localparam logic [15:0] IFC_OFS_CTRL = 16'hfff8;
   localparam logic [7:0] IFC_RST_MASK = 8'hff;
   localparam logic [7:0] IFC_RST_PRIO = 8'hff;
   localparam logic [7:0] IFC_RST_EDGE = 8'h00;
   localparam logic [7:0] IFC_RST_P4CFG = 8'h00;
   localparam logic [7:0] IFC_RST_PSW = 8'h02;
   localparam logic [7:0] IFC_EDGE_USED = 8'h0f;
   localparam logic [7:0] IFC_P4CFG_USED = 8'h07;
   localparam logic [2:0] IFC_P4_SINGLE = 3'h0;
   localparam logic [2:0] IFC_P4_FALL = 3'h1;
   localparam int unsigned IFC_PSW_IE = 7;
   localparam int unsigned IFC_PSW_ISP = 1;
   localparam int unsigned IFC_SRC_WDOG = 0;
   localparam int unsigned IFC_SRC_EXT0 = 1;
   localparam int unsigned IFC_SRC_KEY = 17;
   localparam logic [17:0] IFC_SRC_USED = 18'h3ffff;
   typedef enum logic [1:0] {
      IFC_BUS_IDLE = 2'b00,
      IFC_BUS_DATA = 2'b01
   } ifc_bus_e;
   typedef struct packed {
      logic valid;
      logic [4:0] src;
      logic prio;
   } ifc_ack_s;
   typedef struct packed {
      logic set_en;
      logic clr_en;
      logic trap;
      logic push;
      logic restore;
      logic [7:0] stack_data;
   } ifc_cpu_s;
endpackage : ifc_pkg

// File: rtl/ifc_ctrl.sv
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/10ps
module ifc_ctrl (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   input wire logic [17:0] src_event_in,
   input wire logic [3:0] external_irq_pin_in,
   input wire logic port4_fall_in,
   input wire logic wdog_mode1_in,
   input wire ifc_pkg::ifc_cpu_s cpu_in,
   input wire logic ack_take_in,
   output ifc_pkg::ifc_ack_s ack_out,
   output logic [7:0] cpu_status_word_out,
   output logic [7:0] status_push_out,
   output logic status_push_valid_out,
   output logic port4_fall_mode_out
);
   import ifc_pkg::*;

   logic [17:0] req;
   logic [17:0] mask;
   logic [17:0] prio;
   logic [7:0] rise_en;
   logic [7:0] fall_en;
   logic [7:0] port4_cfg;
   logic [7:0] cpu_status_word;
   logic [3:0] pin_q;
   logic port4_q;
   ifc_bus_e bus_st;
   logic [15:0] a_addr;
   logic a_write;
   logic [1:0] a_size;

   // which of the three byte registers an address hits; 3 means none
   function automatic logic [1:0] slot_reg(input logic [15:0] addr, input logic [15:0] base_al,
                                           input logic [15:0] base_b);
      logic [1:0] w;
      w = 2'd3;
      if (addr == base_al) begin
         w = 2'd0;
      end else if (addr == base_al + 16'h0001) begin
         w = 2'd1;
      end else if (addr == base_b) begin
         w = 2'd2;
      end
      return w;
   endfunction : slot_reg

   // register bit to source index (default priority); 5'h1f marks a slot with no flag,
   // since the high group A byte skips bit 2 and group B holds only three flags
   function automatic logic [4:0] slot_src(input logic [1:0] which, input logic [2:0] pos);
      logic [4:0] s;
      s = 5'h1f;
      case (which)
         2'd0: begin
            s = {2'b00, pos};
         end
         2'd1: begin
            if (pos < 3'd2) begin
               s = 5'd8 + 5'(pos);
            end else if (pos > 3'd2) begin
               s = 5'd7 + 5'(pos);
            end
         end
         2'd2: begin
            if (pos < 3'd3) begin
               s = 5'd15 + 5'(pos);
            end
         end
         default: begin
            s = 5'h1f;
         end
      endcase
      return s;
   endfunction : slot_src

   function automatic logic [17:0] wr_bits(input logic [17:0] cur, input logic [15:0] addr,
                                           input logic [1:0] size, input logic [31:0] d,
                                           input logic [15:0] base_al, input logic [15:0] base_b);
      logic [17:0] r;
      logic [4:0] s;
      logic [1:0] which;
      r = cur;
      which = slot_reg(addr, base_al, base_b);
      for (int b = 0; b < 8; b++) begin
         s = slot_src(which, 3'(b));
         if (s != 5'h1f) begin
            r[s] = d[b];
         end
         s = slot_src(2'd1, 3'(b));
         if (s != 5'h1f && which == 2'd0 && size != 2'd0) begin
            r[s] = d[8 + b];
         end
      end
      return r;
   endfunction : wr_bits

   function automatic logic [7:0] rd_bits(input logic [17:0] v, input logic [15:0] addr,
                                          input logic [15:0] base_al, input logic [15:0] base_b,
                                          input logic [7:0] pad);
      logic [7:0] r;
      logic [4:0] s;
      logic [1:0] which;
      r = 8'h00;
      which = slot_reg(addr, base_al, base_b);
      for (int b = 0; b < 8; b++) begin
         s = slot_src(which, 3'(b));
         if (s != 5'h1f) begin
            r[b] = v[s];
         end else if (which != 2'd3) begin
            r[b] = pad[b];
         end
      end
      return r;
   endfunction : rd_bits

   // no byte lane steering: byte data always sits on bits 7:0 whatever the address, the high group A byte on bits 15:8 of a word
   wire logic data_ph = (bus_st == IFC_BUS_DATA);
   wire logic wr_now = data_ph && a_write;
   wire logic [31:0] wdat = hwdata_in;
   wire logic bitop_wr = wr_now && (a_addr == IFC_OFS_BITOP);
   wire logic [15:0] bit_addr = {8'hff, wdat[15:8]};
   wire logic [2:0] bit_pos = wdat[2:0];
   wire logic bit_val = wdat[3];
   wire logic bit_clr_req = bitop_wr && !bit_val;
   wire logic [4:0] req_slot = slot_src(slot_reg(bit_addr, IFC_OFS_REQ_AL, IFC_OFS_REQ_B), bit_pos);
   wire logic [4:0] mask_slot = slot_src(slot_reg(bit_addr, IFC_OFS_MASK_AL, IFC_OFS_MASK_B), bit_pos);
   wire logic [4:0] prio_slot = slot_src(slot_reg(bit_addr, IFC_OFS_PRIO_AL, IFC_OFS_PRIO_B), bit_pos);

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         bus_st <= IFC_BUS_IDLE;
         a_addr <= 16'h0000;
         a_write <= 1'b0;
         a_size <= 2'd0;
      end else begin
         if (hsel_in && hready_in && htrans_in[1]) begin
            bus_st <= IFC_BUS_DATA;
            a_addr <= haddr_in[15:0];
            a_write <= hwrite_in;
            a_size <= hsize_in[1:0];
         end else begin
            bus_st <= IFC_BUS_IDLE;
         end
      end
   end

   // edge detect on external pins; pins are taken as synchronous
   logic [3:0] rise_hit;
   logic [3:0] fall_hit;
   logic [17:0] hw_set;
   always_comb begin
      rise_hit = external_irq_pin_in & ~pin_q & rise_en[3:0];
      fall_hit = ~external_irq_pin_in & pin_q & fall_en[3:0];
      hw_set = src_event_in & IFC_SRC_USED;
      hw_set[IFC_SRC_EXT0 +: 4] = rise_hit | fall_hit;
      hw_set[IFC_SRC_KEY] = (port4_cfg[2:0] == IFC_P4_FALL) && port4_q && !port4_fall_in;
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         pin_q <= 4'h0;
         port4_q <= 1'b0;
      end else begin
         pin_q <= external_irq_pin_in;
         port4_q <= port4_fall_in;
      end
   end

   // request flags: acknowledge and software clears lose to a same-cycle set
   logic [17:0] next_req;
   always_comb begin
      next_req = req;
      if (wr_now) begin
         next_req = wr_bits(req, a_addr, a_size, wdat, IFC_OFS_REQ_AL, IFC_OFS_REQ_B);
      end
      if (bitop_wr && req_slot != 5'h1f) begin
         next_req[req_slot] = bit_val;
      end
      if (ack_take_in && ack_out.valid) begin
         next_req[ack_out.src] = 1'b0;
      end
      next_req = (next_req | hw_set) & IFC_SRC_USED;
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         req <= 18'h00000;
      end else begin
         req <= next_req;
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         mask <= {IFC_RST_MASK[1:0], IFC_RST_MASK, IFC_RST_MASK};
         prio <= {IFC_RST_PRIO[1:0], IFC_RST_PRIO, IFC_RST_PRIO};
      end else begin
         if (wr_now && !bitop_wr) begin
            mask <= wr_bits(mask, a_addr, a_size, wdat, IFC_OFS_MASK_AL, IFC_OFS_MASK_B);
            prio <= wr_bits(prio, a_addr, a_size, wdat, IFC_OFS_PRIO_AL, IFC_OFS_PRIO_B);
         end else if (bitop_wr && mask_slot != 5'h1f) begin
            mask[mask_slot] <= bit_val;
         end else if (bitop_wr && prio_slot != 5'h1f) begin
            prio[prio_slot] <= bit_val;
         end
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rise_en <= IFC_RST_EDGE;
         fall_en <= IFC_RST_EDGE;
         port4_cfg <= IFC_RST_P4CFG;
      end else if (wr_now && !bitop_wr) begin
         if (a_addr == IFC_OFS_RISE) rise_en <= wdat[7:0] & IFC_EDGE_USED;
         if (a_addr == IFC_OFS_FALL) fall_en <= wdat[7:0] & IFC_EDGE_USED;
         if (a_addr == IFC_OFS_P4CFG) port4_cfg <= wdat[7:0] & IFC_P4CFG_USED;
      end else if (bitop_wr) begin
         if (bit_addr == IFC_OFS_RISE && bit_pos < 3'd4) rise_en[bit_pos] <= bit_val;
         if (bit_addr == IFC_OFS_FALL && bit_pos < 3'd4) fall_en[bit_pos] <= bit_val;
         if (bit_addr == IFC_OFS_P4CFG && bit_pos < 3'd3) port4_cfg[bit_pos] <= bit_val;
      end
   end

   // selection: unmasked pending; high group (prio 0) first, then lowest index
   ifc_ack_s next_ack;
   always_comb begin
      logic [17:0] cand;
      logic have_hi;
      cand = req & ~mask;
      have_hi = |(cand & ~prio);
      next_ack = '0;
      for (int i = IFC_NSRC - 1; i >= 0; i--) begin
         if (cand[i] && (!have_hi || !prio[i])) begin
            next_ack.valid = 1'b1;
            next_ack.src = 5'(i);
            next_ack.prio = prio[i];
         end
      end
      // blocked while disabled or while a higher level is in service
      if (!cpu_status_word[IFC_PSW_IE] || (!cpu_status_word[IFC_PSW_ISP] && next_ack.prio)) begin
         next_ack.valid = 1'b0;
      end
      if (ack_take_in && ack_out.valid) begin
         next_ack.valid = 1'b0;
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         ack_out <= '0;
      end else begin
         ack_out <= next_ack;
      end
   end

   // status word
   logic take;
   assign take = ack_take_in && ack_out.valid;
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         cpu_status_word <= IFC_RST_PSW;
         status_push_out <= 8'h00;
         status_push_valid_out <= 1'b0;
      end else begin
         status_push_valid_out <= take || cpu_in.trap || cpu_in.push;
         status_push_out <= cpu_status_word;
         if (take || cpu_in.trap) begin
            cpu_status_word[IFC_PSW_IE] <= 1'b0;
            if (take) cpu_status_word[IFC_PSW_ISP] <= ack_out.prio;
         end else if (cpu_in.restore) begin
            cpu_status_word <= cpu_in.stack_data;
         end else if (cpu_in.set_en) begin
            cpu_status_word[IFC_PSW_IE] <= 1'b1;
         end else if (cpu_in.clr_en) begin
            cpu_status_word[IFC_PSW_IE] <= 1'b0;
         end else if (wr_now && a_addr == IFC_OFS_PSW) begin
            cpu_status_word <= wdat[7:0];
         end else if (bitop_wr && bit_addr == IFC_OFS_PSW) begin
            cpu_status_word[bit_pos] <= bit_val;
         end
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         cpu_status_word_out <= IFC_RST_PSW;
         port4_fall_mode_out <= 1'b0;
      end else begin
         cpu_status_word_out <= cpu_status_word;
         port4_fall_mode_out <= (port4_cfg[2:0] == IFC_P4_FALL);
      end
   end

   // read data registered at the end of the data phase, after one wait state with hreadyout low
   logic [7:0] rd;
   always_comb begin
      rd = rd_bits(req, a_addr, IFC_OFS_REQ_AL, IFC_OFS_REQ_B, 8'h00)
         | rd_bits(prio, a_addr, IFC_OFS_PRIO_AL, IFC_OFS_PRIO_B, 8'hff);
      if (a_addr == IFC_OFS_MASK_AL || a_addr == IFC_OFS_MASK_AH || a_addr == IFC_OFS_MASK_B) begin
         rd = rd_bits(mask, a_addr, IFC_OFS_MASK_AL, IFC_OFS_MASK_B, 8'hff);
         // watchdog mask reads as 0 in mode 1, a value software must not trust
         if (a_addr == IFC_OFS_MASK_AL && wdog_mode1_in) rd[IFC_SRC_WDOG] = 1'b0;
      end
      if (a_addr == IFC_OFS_RISE) rd = rise_en;
      if (a_addr == IFC_OFS_FALL) rd = fall_en;
      if (a_addr == IFC_OFS_P4CFG) rd = port4_cfg;
      if (a_addr == IFC_OFS_PSW) rd = cpu_status_word;
   end

   logic [31:0] hr;
   always_comb begin
      hr = {24'h000000, rd};
      if (a_size != 2'd0 && a_addr == IFC_OFS_MASK_AL) begin
         hr = {16'h0000, rd_bits(mask, IFC_OFS_MASK_AH, IFC_OFS_MASK_AL, IFC_OFS_MASK_B, 8'hff), rd};
      end
      if (a_size != 2'd0 && a_addr == IFC_OFS_PRIO_AL) begin
         hr = {16'h0000, rd_bits(prio, IFC_OFS_PRIO_AH, IFC_OFS_PRIO_AL, IFC_OFS_PRIO_B, 8'hff), rd};
      end
      if (a_size != 2'd0 && a_addr == IFC_OFS_REQ_AL) begin
         hr = {16'h0000, rd_bits(req, IFC_OFS_REQ_AH, IFC_OFS_REQ_AL, IFC_OFS_REQ_B, 8'h00), rd};
      end
      if (a_addr == IFC_OFS_STATUS) hr = {14'h0000, req};
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         hrdata_out <= 32'h00000000;
         hreadyout_out <= 1'b1;
         hresp_out <= 1'b0;
      end else begin
         hrdata_out <= 32'h00000000;
         hreadyout_out <= 1'b1;
         hresp_out <= 1'b0;
         if (hsel_in && hready_in && htrans_in[1] && !hwrite_in) begin
            hreadyout_out <= 1'b0;
         end
         if (data_ph && !a_write) begin
            hrdata_out <= hr;
         end
      end
   end

   AST_ACK_CLEARS: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (take && !hw_set[ack_out.src]) |=> !req[$past(ack_out.src)]) else $error("ack did not clear flag");
   AST_SET_WINS: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (bit_clr_req && req_slot != 5'h1f && hw_set[req_slot]) |=> req[$past(req_slot)]) else $error("set lost to clear");
   AST_IE_CLR: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (take || cpu_in.trap) |=> !cpu_status_word[IFC_PSW_IE]) else $error("global enable not cleared");
   AST_ISP_COPY: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      take |=> cpu_status_word[IFC_PSW_ISP] == $past(ack_out.prio)) else $error("service level not copied");
   AST_IE_GATE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      ack_out.valid |-> $past(cpu_status_word[IFC_PSW_IE])) else $error("ack while disabled");
   AST_MASK_GATE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      ack_out.valid |-> !$past(mask[next_ack.src])) else $error("masked source offered");
   AST_EDGE_HI: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (rise_en[0] && $rose(external_irq_pin_in[0])) |=> req[IFC_SRC_EXT0]) else $error("rise missed");
   AST_EDGE_UPPER: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      rise_en[7:4] == 4'h0 && fall_en[7:4] == 4'h0) else $error("edge upper bits set");
endmodule : ifc_ctrl

// File: dv/ifc_cpu_model.sv
`timescale 1ns/10ps
module ifc_cpu_model
   import ifc_pkg::*;
(
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire ifc_pkg::ifc_ack_s ack_in,
   input wire logic [7:0] push_in,
   input wire logic push_valid_in,
   input wire logic [3:0] lag_in,
   output logic take_out,
   output logic [4:0] src_out,
   output logic prio_out,
   output logic [7:0] stacked_out,
   output int takes_out
);
   logic armed;
   logic [3:0] seen;
   // re-armed only once the offer drops, so a stale registered offer is never taken twice
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         take_out <= 1'b0;
         armed <= 1'b1;
         seen <= 4'h0;
         src_out <= 5'h0;
         prio_out <= 1'b0;
         stacked_out <= 8'h00;
         takes_out <= 0;
      end else begin
         take_out <= 1'b0;
         if (!ack_in.valid) begin
            armed <= 1'b1;
            seen <= 4'h0;
         end else if (armed && seen >= lag_in) begin
            take_out <= 1'b1;
            armed <= 1'b0;
            src_out <= ack_in.src;
            prio_out <= ack_in.prio;
            takes_out <= takes_out + 1;
         end else if (armed) begin
            seen <= seen + 4'h1;
         end
         if (push_valid_in) begin
            stacked_out <= push_in;
         end
      end
   end
endmodule : ifc_cpu_model

// File: dv/interrupt_flag_mask_priority_ctrl_tb_top.sv
`timescale 1ns/10ps
module interrupt_flag_mask_priority_ctrl_tb_top;
   import ifc_pkg::*;
   logic clk_in, sys_rst_in, hsel, hwrite, hready, hresp, port4_fall, wdog_mode1, take, mprio, push_valid, p4_mode;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [17:0] src_event, ev, exp_req;
   logic [3:0] pins, lag;
   logic [7:0] psw_out, push_data, stacked, exp_psw;
   logic [4:0] msrc;
   ifc_cpu_s cpu;
   ifc_ack_s ack;
   int num_errors = 0, samples_checked = 0, cycles = 0, takes;
   localparam logic [15:0] RA [10] = '{IFC_OFS_P4CFG, IFC_OFS_RISE, IFC_OFS_FALL, IFC_OFS_MASK_AL, IFC_OFS_MASK_AH,
      IFC_OFS_MASK_B, IFC_OFS_PRIO_AL, IFC_OFS_PRIO_AH, IFC_OFS_PRIO_B, IFC_OFS_PSW};
   localparam logic [7:0] RV [10] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h02};

   ifc_ctrl i_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel), .haddr_in(haddr),
      .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
      .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .src_event_in(src_event),
      .external_irq_pin_in(pins), .port4_fall_in(port4_fall), .wdog_mode1_in(wdog_mode1), .cpu_in(cpu),
      .ack_take_in(take), .ack_out(ack), .cpu_status_word_out(psw_out), .status_push_out(push_data),
      .status_push_valid_out(push_valid), .port4_fall_mode_out(p4_mode));

   ifc_cpu_model i_cpu (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .ack_in(ack), .push_in(push_data),
      .push_valid_in(push_valid), .lag_in(lag), .take_out(take), .src_out(msrc), .prio_out(mprio),
      .stacked_out(stacked), .takes_out(takes));

   task automatic wrap_up();
      if (num_errors == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : wrap_up

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
   endtask : tick

   // one single transfer; a hang is cut short by the cycle ceiling
   task automatic bus(input logic [15:0] a, input logic w, input logic [2:0] sz, input logic [31:0] d);
      haddr <= {16'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      hsize <= sz;
      hsel <= 1'b1;
      do @(posedge clk_in); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk_in); while (hready !== 1'b1);
      rd = hrdata;
   endtask : bus

   task automatic cpu_pulse(input logic [12:0] v);
      cpu <= ifc_cpu_s'(v);
      @(posedge clk_in);
      cpu <= '0;
      @(posedge clk_in);
   endtask : cpu_pulse

   task automatic chk_psw();
      tick(2);
      check("status word out", {24'h0, psw_out}, {24'h0, exp_psw});
      bus(IFC_OFS_PSW, 1'b0, 3'h0, 32'h0);
      check("status word read", rd, {24'h0, exp_psw});
   endtask : chk_psw

   task automatic await_take(input int n);
      for (int i = 0; i < 40 && takes < n; i++) @(posedge clk_in);
      tick(4);
      check("take count", takes, n);
   endtask : await_take

   task automatic pulse_events(input logic [17:0] v);
      src_event <= v;
      @(posedge clk_in);
      src_event <= '0;
      exp_req = exp_req | v;
   endtask : pulse_events

   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end

   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         wrap_up();
      end
   end

   initial begin
      sys_rst_in = 1'b1;
      hsel = 1'b0;
      haddr = '0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h0;
      hwdata = '0;
      src_event = '0;
      pins = 4'h0;
      port4_fall = 1'b1;
      wdog_mode1 = 1'b0;
      cpu = '0;
      lag = 4'h0;
      exp_req = '0;
      exp_psw = 8'h02;
      void'($urandom(42));
      tick(20);
      sys_rst_in <= 1'b0;
      @(posedge clk_in);
      check("hresp", {31'h0, hresp}, 32'h0);
      for (int i = 0; i < 10; i++) begin
         bus(RA[i], 1'b0, 3'h0, 32'h0);
         check("reset value", rd, {24'h0, RV[i]});
      end
      for (int c = 0; c < 4; c++) begin
         bus(IFC_OFS_RISE, 1'b1, 3'h0, c[1] ? 32'hff : 32'h0);
         bus(IFC_OFS_FALL, 1'b1, 3'h0, c[0] ? 32'hff : 32'h0);
         bus(IFC_OFS_FALL, 1'b0, 3'h0, 32'h0);
         check("fall enables", rd, c[0] ? 32'h0f : 32'h0);
         for (int e = 0; e < 2; e++) begin
            pins <= e ? 4'h0 : 4'hf;
            tick(4);
            bus(IFC_OFS_REQ_AL, 1'b0, 3'h0, 32'h0);
            check("pin flags", rd, {27'h0, ((e ? c[0] : c[1]) ? 4'hf : 4'h0), 1'b0});
            bus(IFC_OFS_REQ_AL, 1'b1, 3'h0, 32'h0);
         end
      end
      bus(IFC_OFS_RISE, 1'b1, 3'h0, 32'h0);
      bus(IFC_OFS_FALL, 1'b1, 3'h0, 32'h0);
      bus(IFC_OFS_MASK_AL, 1'b1, 3'h1, 32'hff1e);
      bus(IFC_OFS_PRIO_AL, 1'b1, 3'h1, 32'hff7f);
      bus(IFC_OFS_MASK_AH, 1'b0, 3'h0, 32'h0);
      check("mask high", rd, 32'hff);
      bus(IFC_OFS_MASK_AL, 1'b0, 3'h1, 32'h0);
      check("mask word", rd, 32'hff1e);
      bus(IFC_OFS_PRIO_AL, 1'b0, 3'h0, 32'h0);
      check("prio low", rd, 32'h7f);
      // global enable is still clear, so pending events stay pending
      repeat (8) begin
         ev = 18'($urandom()) & 18'h000e1;
         pulse_events(ev);
         bus(IFC_OFS_REQ_AL, 1'b0, 3'h0, 32'h0);
         check("event flags", rd, {24'h0, exp_req[7:0]});
      end
      pulse_events(18'h000e0);
      fork
         bus(IFC_OFS_BITOP, 1'b1, 3'h2, 32'he005);
         begin
            @(posedge clk_in);
            src_event <= 18'h00020;
            @(posedge clk_in);
            src_event <= '0;
         end
      join
      bus(IFC_OFS_BITOP, 1'b1, 3'h2, 32'he006);
      exp_req[6] = 1'b0;
      bus(IFC_OFS_REQ_AL, 1'b0, 3'h0, 32'h0);
      check("set beats clear", rd, {24'h0, exp_req[7:0]});
      bus(IFC_OFS_REQ_AL, 1'b1, 3'h0, 32'h0);
      pulse_events(18'h00060);
      tick(10);
      check("no take while disabled", takes, 0);
      cpu_pulse(13'h1000);
      await_take(1);
      check("ack source", {27'h0, msrc}, 32'h5);
      check("pushed word", {24'h0, stacked}, 32'h82);
      exp_psw = 8'h02;
      chk_psw();
      bus(IFC_OFS_REQ_AL, 1'b0, 3'h0, 32'h0);
      check("flag cleared on ack", rd, 32'h40);
      lag <= 4'h6;
      pulse_events(18'h00080);
      cpu_pulse(13'h1000);
      await_take(2);
      check("programmed priority", {26'h0, mprio, msrc}, 32'h7);
      exp_psw = 8'h00;
      chk_psw();
      bus(IFC_OFS_MASK_AL, 1'b1, 3'h0, 32'h5e);
      cpu_pulse(13'h0182);
      exp_psw = 8'h82;
      chk_psw();
      tick(10);
      check("masked source held", takes, 2);
      bus(IFC_OFS_MASK_AL, 1'b1, 3'h0, 32'h1e);
      await_take(3);
      check("unmasked source", {27'h0, msrc}, 32'h6);
      exp_psw = 8'h02;
      chk_psw();
      cpu_pulse(13'h1000);
      cpu_pulse(13'h0400);
      check("trap push", {24'h0, stacked}, 32'h82);
      chk_psw();
      cpu_pulse(13'h1000);
      cpu_pulse(13'h0200);
      tick(2);
      check("push", {24'h0, stacked}, 32'h82);
      cpu_pulse(13'h0800);
      chk_psw();
      bus(IFC_OFS_PSW, 1'b1, 3'h0, 32'h80);
      exp_psw = 8'h80;
      chk_psw();
      for (int m = 0; m < 2; m++) begin
         bus(IFC_OFS_P4CFG, 1'b1, 3'h0, m);
         tick(2);
         check("port4 mode", {31'h0, p4_mode}, m);
         port4_fall <= 1'b0;
         tick(4);
         port4_fall <= 1'b1;
         bus(IFC_OFS_REQ_B, 1'b0, 3'h0, 32'h0);
         check("port4 flag", rd, m ? 32'h4 : 32'h0);
         bus(IFC_OFS_REQ_B, 1'b1, 3'h0, 32'h0);
      end
      bus(IFC_OFS_MASK_AL, 1'b1, 3'h0, 32'h1f);
      wdog_mode1 <= 1'b1;
      tick(2);
      bus(IFC_OFS_MASK_AL, 1'b0, 3'h0, 32'h0);
      check("wdog mask in mode 1", rd, 32'h1e);
      wrap_up();
   end
endmodule : interrupt_flag_mask_priority_ctrl_tb_top
